// ### core/esi_addr_idx.sv
// Indexed address adder with indirect register window check
`timescale 1ns/1ps
`default_nettype none
`include "esi_cfg.svh"
module esi_addr_idx #(
    parameter int ADDR_W = `ESI_ADDR_W,
    parameter int OFF_W = `ESI_OFF_W,
    parameter logic [ADDR_W-1:0] IND_TOP0 = `ESI_IND_TOP0,
    parameter logic [ADDR_W-1:0] IND_TOP1 = `ESI_IND_TOP1,
    parameter logic [ADDR_W-1:0] IND_TOP2 = `ESI_IND_TOP2
) (
    // Operands
    input wire logic [ADDR_W-1:0] i_base,
    input wire logic [OFF_W-1:0] i_offset,
    // Results
    output logic [ADDR_W-1:0] o_addr,
    output logic o_indirect
);
    initial begin
        if (OFF_W >= ADDR_W) begin
            $error("esi_addr_idx: offset must be narrower than address");
        end
    end

    // Sum wraps within the data space, so any byte is reachable
    assign o_addr = ADDR_W'(i_base + {{(ADDR_W-OFF_W){1'b0}}, i_offset});

    // Each pointer owns a small group of indirect access registers
    wire logic in0 = (o_addr <= IND_TOP0) && (o_addr >= ADDR_W'(IND_TOP0 - `ESI_IND_SPAN));
    wire logic in1 = (o_addr <= IND_TOP1) && (o_addr >= ADDR_W'(IND_TOP1 - `ESI_IND_SPAN));
    wire logic in2 = (o_addr <= IND_TOP2) && (o_addr >= ADDR_W'(IND_TOP2 - `ESI_IND_SPAN));
    assign o_indirect = in0 | in1 | in2;
endmodule
`default_nettype wire

// ### core/esi_cfg.svh
// Constants for the extended stack instruction executor
`ifndef ESI_CFG_SVH
`define ESI_CFG_SVH

`define ESI_ADDR_W 12
`define ESI_PC_W 21
`define ESI_OFF_W 7
`define ESI_SUBK_W 6
`define ESI_OP_PUSH_LIT 8'hfa
`define ESI_OP_SUB_PTR 8'he9
`define ESI_OP_MOVE_HI 9'h1d7
`define ESI_OP_MOVE_W2 4'hf
`define ESI_SEL_RETURN 2'h3
`define ESI_FP2_ONEHOT 3'h4
`define ESI_IND_TOP0 12'hfef
`define ESI_IND_TOP1 12'hfe7
`define ESI_IND_TOP2 12'hfdf
`define ESI_IND_SPAN 12'h004
`define ESI_ZERO_BYTE 8'h00
`define ESI_RST_ADDR 12'h000
`define ESI_RST_PC 21'h000000
`define ESI_RST_BYTE 8'h00

`endif

// ### core/esi_exec.sv
// Executor for the software stack instructions of the extended set
// Summary of operation
// - Indexed move adds separate 7-bit offsets to the stack frame pointer.
// - Source and destination may lie anywhere in the 4096-byte space.
// - Source in an indirect register reads as zero.
// - Destination in an indirect register suppresses the write.
// - Push literal stores its byte at the stack frame pointer.
// - Push literal then lowers the stack frame pointer by one.
// - Push literal opcode is fa with literal low byte, one cycle, no flags.
// - Subtract literal subtracts a 6-bit value from the selected pointer.
// - Subtract opcode is e9 with 2-bit selector and 6-bit literal, no flags.
// - Subtract and return lowers stack frame pointer and loads the counter in the same cycle.
// - Subtract and return takes two cycles, the second a no-operation.
// - Selector value three means subtract and return on the frame pointer.
// - Extended instructions start only while the configuration bit is one; indexed move word two does not check it.
`timescale 1ns/1ps
`default_nettype none
`include "esi_cfg.svh"
module esi_exec #(
    parameter int ADDR_W = `ESI_ADDR_W,
    parameter int PC_W = `ESI_PC_W
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_N,
    // Instruction stream and configuration
    input wire logic I_INSTR_VALID,
    input wire logic [15:0] I_INSTR,
    input wire logic I_EXTENDED_SET_CONFIG_BIT,
    // Current pointer and return stack state
    input wire logic [ADDR_W-1:0] I_FILE_SELECT_POINTER0,
    input wire logic [ADDR_W-1:0] I_FILE_SELECT_POINTER1,
    input wire logic [ADDR_W-1:0] I_STACK_FRAME_POINTER,
    input wire logic [PC_W-1:0] I_RETURN_STACK_TOP,
    // Data memory read data
    input wire logic [7:0] I_MEM_RDATA,
    // Data memory request
    output logic [ADDR_W-1:0] O_MEM_ADDR,
    output logic O_MEM_RD,
    output logic O_MEM_WR,
    output logic [7:0] O_MEM_WDATA,
    // Pointer and counter updates
    output logic [2:0] O_FP_WE,
    output logic [ADDR_W-1:0] O_FP_VALUE,
    output logic O_PC_LOAD,
    output logic [PC_W-1:0] O_PC_VALUE,
    // Executor status
    output logic O_BUSY
);
    initial begin
        if (ADDR_W != `ESI_ADDR_W || PC_W < ADDR_W) begin
            $error("esi_exec: unsupported address or counter width");
        end
    end

    esi_pkg::esi_state_t state_q, state_d;
    logic [ADDR_W-1:0] mem_addr_q, mem_addr_d, fp_value_q, fp_value_d;
    logic mem_rd_q, mem_rd_d, mem_wr_q, mem_wr_d, pc_load_q, pc_load_d;
    logic [7:0] mem_wdata_q, mem_wdata_d, rdata_q, rdata_d;
    logic [2:0] fp_we_q, fp_we_d;
    logic [PC_W-1:0] pc_value_q, pc_value_d;
    logic src_ind_q, src_ind_d;

    // Decode of the current word
    wire logic idle = (state_q == esi_pkg::ESI_IDLE);
    wire logic accept = I_INSTR_VALID && idle && I_EXTENDED_SET_CONFIG_BIT;
    wire logic is_push = (I_INSTR[15:8] == `ESI_OP_PUSH_LIT);
    wire logic is_subop = (I_INSTR[15:8] == `ESI_OP_SUB_PTR);
    wire logic is_ret = is_subop && (I_INSTR[7:6] == `ESI_SEL_RETURN);
    wire logic is_sub = is_subop && !is_ret;
    wire logic is_move1 = (I_INSTR[15:7] == `ESI_OP_MOVE_HI);
    wire logic do_push = accept && is_push;
    wire logic do_sub = accept && is_sub;
    wire logic do_ret = accept && is_ret;
    wire logic do_move1 = accept && is_move1;
    wire logic in_dst = (state_q == esi_pkg::ESI_MOVE_DST);
    wire logic w2_ok = I_INSTR[15:12] == `ESI_OP_MOVE_W2;
    wire logic do_move2 = in_dst && I_INSTR_VALID && w2_ok;
    wire logic [7:0] lit8 = I_INSTR[7:0];
    wire logic [`ESI_SUBK_W-1:0] lit6 = I_INSTR[5:0];

    // Both addresses are frame-relative; the same adder serves each word
    logic [ADDR_W-1:0] idx_addr;
    logic idx_ind;
    esi_addr_idx #(
        .ADDR_W(ADDR_W),
        .OFF_W(`ESI_OFF_W)
    ) u_idx (
        .i_base(I_STACK_FRAME_POINTER),
        .i_offset(I_INSTR[6:0]),
        .o_addr(idx_addr),
        .o_indirect(idx_ind)
    );

    // Pointer selection and arithmetic
    wire logic [ADDR_W-1:0] fp_sel = (I_INSTR[7:6] == 2'h0) ? I_FILE_SELECT_POINTER0 :
        (I_INSTR[7:6] == 2'h1) ? I_FILE_SELECT_POINTER1 : I_STACK_FRAME_POINTER;
    wire logic [ADDR_W-1:0] k_ext = {{(ADDR_W-`ESI_SUBK_W){1'b0}}, lit6};
    wire logic [ADDR_W-1:0] fp_minus_k = ADDR_W'(fp_sel - k_ext);
    wire logic [ADDR_W-1:0] fp2_dec = ADDR_W'(I_STACK_FRAME_POINTER - 1'b1);
    wire logic [2:0] sel_onehot = 3'(3'h1 << I_INSTR[7:6]);

    // Read byte is taken in the cycle the read strobe is high; hold it if word two lags
    wire logic [7:0] src_byte = mem_rd_q ? I_MEM_RDATA : rdata_q;
    wire logic [7:0] move_byte = src_ind_q ? `ESI_ZERO_BYTE : src_byte;
    assign rdata_d = mem_rd_q ? I_MEM_RDATA : rdata_q;
    assign src_ind_d = do_move1 ? idx_ind : src_ind_q;

    // Memory request for the next cycle
    assign mem_rd_d = do_move1;
    assign mem_wr_d = do_push || (do_move2 && !idx_ind);
    assign mem_addr_d = do_push ? I_STACK_FRAME_POINTER :
        (do_move1 || do_move2) ? idx_addr : mem_addr_q;
    assign mem_wdata_d = do_push ? lit8 : do_move2 ? move_byte : mem_wdata_q;

    // Pointer and counter updates; no status flags are touched
    assign fp_we_d = (do_push || do_ret) ? `ESI_FP2_ONEHOT : do_sub ? sel_onehot : 3'h0;
    assign fp_value_d = do_push ? fp2_dec : (do_sub || do_ret) ? fp_minus_k : fp_value_q;
    assign pc_load_d = do_ret;
    assign pc_value_d = do_ret ? I_RETURN_STACK_TOP : pc_value_q;

    // Sequencing of two-cycle instructions
    assign state_d = do_move1 ? esi_pkg::ESI_MOVE_DST :
        do_ret ? esi_pkg::ESI_RET_NOP :
        (in_dst && !I_INSTR_VALID) ? esi_pkg::ESI_MOVE_DST : esi_pkg::ESI_IDLE;

    // State and output registers
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            state_q <= esi_pkg::ESI_IDLE;
            mem_addr_q <= `ESI_RST_ADDR;
            mem_rd_q <= 1'b0;
            mem_wr_q <= 1'b0;
            mem_wdata_q <= `ESI_RST_BYTE;
            rdata_q <= `ESI_RST_BYTE;
            src_ind_q <= 1'b0;
            fp_we_q <= 3'h0;
            fp_value_q <= `ESI_RST_ADDR;
            pc_load_q <= 1'b0;
            pc_value_q <= `ESI_RST_PC;
        end else begin
            state_q <= state_d;
            mem_addr_q <= mem_addr_d;
            mem_rd_q <= mem_rd_d;
            mem_wr_q <= mem_wr_d;
            mem_wdata_q <= mem_wdata_d;
            rdata_q <= rdata_d;
            src_ind_q <= src_ind_d;
            fp_we_q <= fp_we_d;
            fp_value_q <= fp_value_d;
            pc_load_q <= pc_load_d;
            pc_value_q <= pc_value_d;
        end
    end

    // Busy flag tracks the second cycle of two-cycle instructions
    logic busy_q;
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_d != esi_pkg::ESI_IDLE);
        end
    end

    // Port drive
    assign O_MEM_ADDR = mem_addr_q;
    assign O_MEM_RD = mem_rd_q;
    assign O_MEM_WR = mem_wr_q;
    assign O_MEM_WDATA = mem_wdata_q;
    assign O_FP_WE = fp_we_q;
    assign O_FP_VALUE = fp_value_q;
    assign O_PC_LOAD = pc_load_q;
    assign O_PC_VALUE = pc_value_q;
    assign O_BUSY = busy_q;

    // Checks on the executor behaviour
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    sequence s_ret_issue;
        do_ret;
    endsequence

    sequence s_quiet;
        !O_MEM_WR && !O_MEM_RD && !O_PC_LOAD && (O_FP_WE == 3'h0);
    endsequence

    AST_PUSH_STORE: assert property (do_push |=> O_MEM_WR &&
        O_MEM_ADDR == $past(I_STACK_FRAME_POINTER) && O_MEM_WDATA == $past(I_INSTR[7:0]))
        else $error("push literal stored wrong byte or address");
    AST_PUSH_DEC: assert property (do_push |=> O_FP_WE == 3'h4 &&
        O_FP_VALUE == ADDR_W'($past(I_STACK_FRAME_POINTER) - 1'b1))
        else $error("push literal did not lower the frame pointer by one");
    AST_PUSH_ONE: assert property (do_push |=> !O_BUSY)
        else $error("push literal took more than one cycle");
    AST_SUB_PTR: assert property (do_sub |=> O_FP_VALUE ==
        ADDR_W'($past(fp_sel) - {6'h00, $past(I_INSTR[5:0])}))
        else $error("subtract literal result wrong");
    AST_SUB_SEL: assert property (do_sub |=>
        O_FP_WE == 3'(3'h1 << $past(I_INSTR[7:6])) && !O_PC_LOAD)
        else $error("subtract literal wrote the wrong pointer");
    AST_RET_LOAD: assert property (s_ret_issue |=> O_PC_LOAD &&
        O_PC_VALUE == $past(I_RETURN_STACK_TOP) && O_FP_WE == 3'h4)
        else $error("subtract and return did not load the counter");
    AST_RET_NOP: assert property (s_ret_issue |=> O_BUSY ##1 s_quiet)
        else $error("second cycle of subtract and return was not idle");
    AST_RET_FP2: assert property (s_ret_issue |=> O_FP_VALUE ==
        ADDR_W'($past(I_STACK_FRAME_POINTER) - {6'h00, $past(I_INSTR[5:0])}))
        else $error("subtract and return acted on the wrong pointer");
    AST_CFG_OFF: assert property (!I_EXTENDED_SET_CONFIG_BIT && idle |=> s_quiet)
        else $error("extended instruction ran while disabled");
    AST_MOVE_SRC: assert property (do_move1 |=> O_MEM_RD && O_MEM_ADDR ==
        ADDR_W'($past(I_STACK_FRAME_POINTER) + {5'h00, $past(I_INSTR[6:0])}))
        else $error("indexed move source address wrong");
    AST_MOVE_DST: assert property (do_move2 && !idx_ind |=> O_MEM_WR &&
        O_MEM_ADDR == $past(idx_addr) && !O_MEM_RD)
        else $error("indexed move write missing");
    AST_MOVE_IND_DST: assert property (do_move2 && idx_ind |=> !O_MEM_WR)
        else $error("indexed move wrote an indirect register");
    AST_MOVE_IND_SRC: assert property (do_move2 && !idx_ind && src_ind_q |=>
        O_MEM_WDATA == 8'h00)
        else $error("indirect source did not read as zero");
endmodule
`default_nettype wire

// ### core/esi_pkg.sv
// Types shared by the extended stack instruction executor
package esi_pkg;
    typedef enum logic [1:0] {
        ESI_IDLE     = 2'b00,
        ESI_MOVE_DST = 2'b01,
        ESI_RET_NOP  = 2'b10
    } esi_state_t;
endpackage

// ### verification/tb_esi_exec.sv
// Self-checking testbench for the extended stack instruction executor
`timescale 1ns/1ps
`default_nettype none
module tb_esi_exec;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic valid = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic cfg = 1'b1;
    logic [11:0] fp0 = 12'h000;
    logic [11:0] fp1 = 12'h000;
    logic [11:0] fp2 = 12'h000;
    logic [20:0] top = 21'h000000;
    logic [7:0] rdata = 8'h00;
    logic [11:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
    logic [2:0] fp_we;
    logic [11:0] fp_val;
    logic pc_load;
    logic [20:0] pc_val;
    logic busy;
    int err_total = 0;
    int num_checks = 0;

    // Device under test
    esi_exec dut (
        .I_CLK(clk), .I_RST_N(rst_n), .I_INSTR_VALID(valid), .I_INSTR(instr),
        .I_EXTENDED_SET_CONFIG_BIT(cfg), .I_FILE_SELECT_POINTER0(fp0),
        .I_FILE_SELECT_POINTER1(fp1), .I_STACK_FRAME_POINTER(fp2),
        .I_RETURN_STACK_TOP(top), .I_MEM_RDATA(rdata), .O_MEM_ADDR(addr),
        .O_MEM_RD(rd), .O_MEM_WR(wr), .O_MEM_WDATA(wdata), .O_FP_WE(fp_we),
        .O_FP_VALUE(fp_val), .O_PC_LOAD(pc_load), .O_PC_VALUE(pc_val), .O_BUSY(busy)
    );

    // Clock at 50 MHz
    initial begin
        forever #10 clk = ~clk;
    end

    // Compares one observed value against its expectation
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Presents a word and lets the taking edge pass
    task automatic issue(input logic [15:0] w);
        valid = 1'b1;
        instr = w;
        @(posedge clk);
        #1;
    endtask

    // Drops the valid line for one cycle
    task automatic idle();
        valid = 1'b0;
        @(posedge clk);
        #1;
    endtask

    // Push literal stores at the frame pointer and lowers it
    task automatic t_push();
        fp2 = 12'h1ec;
        issue(16'hfa08);
        chk("push wr", wr, 1);
        chk("push addr", addr, 12'h1ec);
        chk("push data", wdata, 8'h08);
        chk("push we", fp_we, 3'h4);
        chk("push fp", fp_val, 12'h1eb);
        chk("push busy", busy, 0);
        idle();
        chk("push wr end", wr, 0);
    endtask

    // Subtract literal on every pointer, back to back
    task automatic t_sub();
        logic [11:0] exp_v [3];
        fp0 = 12'h3ff;
        fp1 = 12'h800;
        fp2 = 12'h03f;
        exp_v = '{12'h3c0, 12'h7c1, 12'h000};
        for (int s = 0; s < 3; s++) begin
            issue({8'he9, s[1:0], 6'h3f});
            chk("sub we", fp_we, 3'h1 << s);
            chk("sub fp", fp_val, exp_v[s]);
            chk("sub pc", pc_load, 0);
        end
        idle();
    endtask

    // Subtract and return, with a word offered in its dead cycle
    task automatic t_subret();
        fp2 = 12'h3ff;
        top = 21'h12345;
        issue(16'he9e3);
        chk("ret load", pc_load, 1);
        chk("ret pc", pc_val, 21'h12345);
        chk("ret we", fp_we, 3'h4);
        chk("ret fp", fp_val, 12'h3dc);
        chk("ret busy", busy, 1);
        issue(16'hfa55);
        chk("ret nop wr", wr, 0);
        chk("ret nop we", fp_we, 3'h0);
        chk("ret nop load", pc_load, 0);
        chk("ret busy end", busy, 0);
        idle();
    endtask

    // Indexed move: read in word one, write in word two
    task automatic t_move(input logic [11:0] fp, input logic [6:0] zs, input logic [6:0] zd,
            input logic [7:0] rb, input logic ewr, input logic [7:0] ed, input int gap);
        fp2 = fp;
        issue({8'heb, 1'b1, zs});
        chk("mv rd", rd, 1);
        chk("mv src", addr, 12'(fp + {5'h00, zs}));
        chk("mv busy", busy, 1);
        chk("mv we", fp_we, 3'h0);
        rdata = rb;
        repeat (gap) begin
            idle();
            rdata = ~rb;
            chk("mv stall rd", rd, 0);
            chk("mv stall busy", busy, 1);
        end
        issue({8'hf0, 1'b0, zd});
        chk("mv wr", wr, ewr);
        if (ewr) begin
            chk("mv dst", addr, 12'(fp + {5'h00, zd}));
            chk("mv data", wdata, ed);
        end
        chk("mv busy end", busy, 0);
        idle();
    endtask

    // Indexed move whose second word lacks its marker is dropped
    task automatic t_abort();
        fp2 = 12'h080;
        issue(16'heb85);
        issue(16'h0006);
        chk("abort wr", wr, 0);
        chk("abort busy", busy, 0);
        idle();
    endtask

    // With the configuration bit low nothing executes
    task automatic t_off();
        cfg = 1'b0;
        fp2 = 12'h100;
        issue(16'hfa08);
        chk("off wr", wr, 0);
        chk("off we", fp_we, 3'h0);
        issue(16'he9e3);
        chk("off load", pc_load, 0);
        idle();
        cfg = 1'b1;
    endtask

    // Prints the verdict and stops
    task automatic end_of_test();
        if (err_total == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #100000;
        err_total++;
        end_of_test();
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        #1;
        chk("rst busy", busy, 0);
        chk("rst wr", wr, 0);
        rst_n = 1'b1;
        t_push();
        t_sub();
        t_subret();
        // Destinations stay clear of the counter low and return top bytes
        t_move(12'h080, 7'h05, 7'h06, 8'h33, 1'b1, 8'h33, 0);
        t_move(12'hf80, 7'h7f, 7'h00, 8'ha5, 1'b1, 8'ha5, 0);
        t_move(12'hfe0, 7'h0f, 7'h00, 8'h5a, 1'b1, 8'h00, 0);
        t_move(12'hfe0, 7'h01, 7'h0f, 8'h77, 1'b0, 8'h00, 0);
        t_move(12'h200, 7'h10, 7'h11, 8'hc3, 1'b1, 8'hc3, 2);
        t_abort();
        t_off();
        t_push();
        end_of_test();
    end
endmodule
`default_nettype wire
